// ===== hdl/rst_gen_pkg.sv
package rst_gen_pkg;

  // Register word addresses on the plain port
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_OUTPORT = 8'h08;
  localparam logic [7:0] ADDR_IODIR   = 8'h0C;
  localparam logic [7:0] ADDR_IOOUT   = 8'h10;
  localparam logic [7:0] ADDR_FUNCSEL = 8'h14;

  // Prescaler setting codes
  localparam logic [1:0] PRESC_32K    = 2'h0;
  localparam logic [1:0] PRESC_76K    = 2'h1;
  localparam logic [1:0] PRESC_153K   = 2'h2;
  localparam logic [1:0] PRESC_RESET  = PRESC_153K;

  // Oscillator edges per filter tick, per prescaler setting
  localparam logic [6:0] DIV_32K      = 7'h0D;
  localparam logic [6:0] DIV_76K      = 7'h1E;
  localparam logic [6:0] DIV_153K     = 7'h3C;

  // Filter ticks of steady low before a reset is accepted
  localparam logic [2:0] ACCEPT_TICKS = 3'h3;

  // Key combination codes
  localparam logic [1:0] KEY_NONE     = 2'h0;
  localparam logic [1:0] KEY_ALL4     = 2'h1;
  localparam logic [1:0] KEY_FIRST3   = 2'h2;
  localparam logic [1:0] KEY_FIRST2   = 2'h3;

  // Timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int OSC_LOSS_NS    = 100_000;
  localparam int OSC_LOSS_CYC   = OSC_LOSS_NS / CLK_PERIOD_NS;
  localparam int KEY_HOLD_MS    = 1500;
  localparam int KEY_HOLD_CYC   = KEY_HOLD_MS * 1_000_000 / CLK_PERIOD_NS;

  // Values loaded by the internal reset, except CAUSE_W1C_LSB, which nothing uses
  localparam logic [15:0] PC_RESET     = 16'h0110;
  localparam logic [7:0]  OUTPORT_INIT = 8'hFF;
  localparam logic [11:0] IO_INIT      = 12'h000;
  localparam logic [3:0]  FUNCSEL_INIT = 4'h0;
  localparam logic [4:0]  CAUSE_W1C_LSB = 5'h0;

  // Events from the processor core
  typedef struct packed {
    logic ext_write;
    logic instr_done;
    logic int_flag_set;
    logic int_flag_clr;
    logic sp1_load;
    logic sp2_load;
  } cpu_event_t;

  // State handed to the processor core
  typedef struct packed {
    logic        cpu_reset;
    logic [15:0] pc_start;
    logic        int_flag;
    logic        ext_flag;
    logic        int_mask;
  } cpu_state_t;

  typedef enum logic [1:0] {
    FILT_IDLE   = 2'b00,
    FILT_COUNT  = 2'b01,
    FILT_ACCEPT = 2'b11
  } filt_state_t;

endpackage

// ===== hdl/noise_reject_filter.sv
`timescale 1ns/1ps
module noise_reject_filter (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Filter control
  input  wire logic tick,
  input  wire logic bypass,
  input  wire logic raw_low,
  // Result
  output logic      filt_low_reg
);
  import rst_gen_pkg::*;

  filt_state_t state_reg;
  filt_state_t state_next;
  logic [2:0]  cnt_reg;
  logic [2:0]  cnt_next;
  wire logic   reached;

  assign reached = (cnt_reg == ACCEPT_TICKS - 3'h1) && tick;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      FILT_IDLE: begin
        cnt_next = 3'h0;
        if (raw_low) begin
          state_next = FILT_COUNT;
        end
      end
      FILT_COUNT: begin
        if (!raw_low) begin
          state_next = FILT_IDLE;
          cnt_next   = 3'h0;
        end else if (reached) begin
          state_next = FILT_ACCEPT;
          cnt_next   = ACCEPT_TICKS;
        end else if (tick) begin
          cnt_next = cnt_reg + 3'h1;
        end
      end
      FILT_ACCEPT: begin
        if (!raw_low) begin
          state_next = FILT_IDLE;
          cnt_next   = 3'h0;
        end
      end
      default: begin
        state_next = FILT_IDLE;
        cnt_next   = 3'h0;
      end
    endcase
    if (bypass && raw_low) begin
      state_next = FILT_ACCEPT;
      cnt_next   = ACCEPT_TICKS;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg    <= FILT_IDLE;
      cnt_reg      <= 3'h0;
      filt_low_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      filt_low_reg <= bypass ? raw_low : (state_next == FILT_ACCEPT);
    end
  end

  property p_reject_short;
    @(posedge clock) disable iff (rst)
      (!bypass && state_reg != FILT_ACCEPT) |=> (!filt_low_reg || $past(bypass) ||
        $past(state_next) == FILT_ACCEPT);
  endproperty
  a_reject_short: assert property (p_reject_short)
    else $error("filter accepted without full count");

  property p_accept_count;
    @(posedge clock) disable iff (rst)
      (!bypass && state_reg == FILT_COUNT && state_next == FILT_ACCEPT) |->
        cnt_reg == ACCEPT_TICKS - 3'h1 && tick;
  endproperty
  a_accept_count: assert property (p_accept_count)
    else $error("filter accepted at wrong tick count");

endmodule

// ===== hdl/initial_reset_generator.sv
`timescale 1ns/1ps
module initial_reset_generator #(
  parameter logic [1:0] KEY_MODE      = 2'h1,
  parameter bit         KEY_HOLD_EN   = 1'b0,
  parameter bit         IO_PULLUP     = 1'b1,
  parameter int         KEY_HOLD_CYCLES = 30_000_000
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // Register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic [31:0]                  reg_rdata,
  // External pins
  input  wire logic                    reset_pin_n,
  input  wire logic [3:0]              key_input_ports,
  input  wire logic                    low_speed_oscillator,
  // Processor core
  input  wire rst_gen_pkg::cpu_event_t cpu_event,
  output rst_gen_pkg::cpu_state_t      cpu_state,
  // Shared pins
  output logic [7:0]                   output_port_pins,
  output logic [11:0]                  io_port_out,
  output logic [11:0]                  io_port_oe_n,
  output logic [11:0]                  io_port_pullup,
  output logic [3:0]                   special_func_sel
);
  import rst_gen_pkg::*;

  function automatic logic keys_all_low(input logic [1:0] mode, input logic [3:0] k);
    case (mode)
      KEY_ALL4:   keys_all_low = (k == 4'h0);
      KEY_FIRST3: keys_all_low = (k[2:0] == 3'h0);
      KEY_FIRST2: keys_all_low = (k[1:0] == 2'h0);
      default:    keys_all_low = 1'b0;
    endcase
  endfunction

  function automatic logic [6:0] presc_div(input logic [1:0] sel);
    case (sel)
      PRESC_32K: presc_div = DIV_32K;
      PRESC_76K: presc_div = DIV_76K;
      default:   presc_div = DIV_153K;
    endcase
  endfunction

  logic [1:0]  presc_reg;
  logic        osc_prev_reg;
  logic [6:0]  div_cnt_reg;
  logic        tick_reg;
  logic [10:0] loss_cnt_reg;
  logic        osc_run_reg;
  logic [24:0] hold_cnt_reg;
  logic        key_qual_reg;
  logic        pin_filt;
  logic        key_filt;
  logic        active_reg;
  logic [2:0]  cause_reg;
  logic        sp1_done_reg;
  logic        sp2_done_reg;

  wire logic osc_rise;
  wire logic div_wrap;
  wire logic loss_hit;
  wire logic key_low;
  wire logic key_raw;
  wire logic active_next;
  wire logic hold_done;
  wire logic wr_ctrl;
  wire logic wr_status;
  wire logic wr_outport;
  wire logic wr_iodir;
  wire logic wr_ioout;
  wire logic wr_funcsel;
  wire logic [31:0] rd_mux;

  // Oscillator edge and prescaled tick
  assign osc_rise = low_speed_oscillator && !osc_prev_reg;
  assign div_wrap = osc_rise && (div_cnt_reg >= presc_div(presc_reg) - 7'h1);

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_prev_reg <= 1'b0;
      div_cnt_reg  <= 7'h0;
      tick_reg     <= 1'b0;
    end else begin
      osc_prev_reg <= low_speed_oscillator;
      tick_reg     <= div_wrap;
      if (div_wrap) begin
        div_cnt_reg <= 7'h0;
      end else if (osc_rise) begin
        div_cnt_reg <= div_cnt_reg + 7'h1;
      end
    end
  end

  assign loss_hit = (loss_cnt_reg == 11'(OSC_LOSS_CYC - 1));

  always_ff @(posedge clock) begin
    if (rst) begin
      loss_cnt_reg <= 11'h000;
      osc_run_reg  <= 1'b0;
    end else if (osc_rise) begin
      loss_cnt_reg <= 11'h000;
      osc_run_reg  <= 1'b1;
    end else if (loss_hit) begin
      osc_run_reg  <= 1'b0;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + 11'h001;
    end
  end

  assign key_low = keys_all_low(KEY_MODE, key_input_ports);

  assign hold_done = (hold_cnt_reg == 25'(KEY_HOLD_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (rst || !key_low) begin
      hold_cnt_reg <= 25'h000_0000;
      key_qual_reg <= 1'b0;
    end else if (hold_done) begin
      key_qual_reg <= 1'b1;
    end else begin
      hold_cnt_reg <= hold_cnt_reg + 25'h000_0001;
    end
  end

  assign key_raw = KEY_HOLD_EN ? key_qual_reg : key_low;

  noise_reject_filter u_pin_filter (
    .clock        (clock),
    .rst          (rst),
    .tick         (tick_reg),
    .bypass       (!osc_run_reg),
    .raw_low      (!reset_pin_n),
    .filt_low_reg (pin_filt)
  );

  noise_reject_filter u_key_filter (
    .clock        (clock),
    .rst          (rst),
    .tick         (tick_reg),
    .bypass       (!osc_run_reg),
    .raw_low      (key_raw),
    .filt_low_reg (key_filt)
  );

  assign active_next = pin_filt || key_filt || !osc_run_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      active_reg <= 1'b1;
      cause_reg  <= 3'h0;
    end else begin
      active_reg <= active_next;
      // Set wins over write-one clear
      cause_reg  <= (cause_reg & ~(wr_status ? reg_wdata[2:0] : 3'h0))
                  | {!osc_run_reg, key_filt, pin_filt};
    end
  end

  // Processor state
  always_ff @(posedge clock) begin
    if (rst || active_reg) begin
      cpu_state.cpu_reset <= 1'b1;
      cpu_state.pc_start  <= PC_RESET;
      cpu_state.int_flag  <= 1'b0;
      cpu_state.ext_flag  <= 1'b0;
      cpu_state.int_mask  <= 1'b1;
      sp1_done_reg        <= 1'b0;
      sp2_done_reg        <= 1'b0;
    end else begin
      cpu_state.cpu_reset <= 1'b0;
      cpu_state.pc_start  <= PC_RESET;
      if (cpu_event.int_flag_set) begin
        cpu_state.int_flag <= 1'b1;
      end else if (cpu_event.int_flag_clr) begin
        cpu_state.int_flag <= 1'b0;
      end
      if (cpu_event.ext_write) begin
        cpu_state.ext_flag <= 1'b1;
      end else if (cpu_event.instr_done) begin
        cpu_state.ext_flag <= 1'b0;
      end
      if (cpu_event.sp1_load && cpu_event.sp2_load) begin
        sp1_done_reg       <= 1'b1;
        sp2_done_reg       <= 1'b1;
        cpu_state.int_mask <= 1'b0;
      end else if (cpu_event.sp1_load) begin
        sp1_done_reg       <= 1'b1;
        sp2_done_reg       <= sp1_done_reg ? 1'b0 : sp2_done_reg;
        cpu_state.int_mask <= !(sp2_done_reg && !sp1_done_reg);
      end else if (cpu_event.sp2_load) begin
        sp2_done_reg       <= 1'b1;
        sp1_done_reg       <= sp2_done_reg ? 1'b0 : sp1_done_reg;
        cpu_state.int_mask <= !(sp1_done_reg && !sp2_done_reg);
      end
    end
  end

  // Register decode
  assign wr_ctrl    = reg_write && (reg_addr == ADDR_CTRL);
  assign wr_status  = reg_write && (reg_addr == ADDR_STATUS);
  assign wr_outport = reg_write && (reg_addr == ADDR_OUTPORT);
  assign wr_iodir   = reg_write && (reg_addr == ADDR_IODIR);
  assign wr_ioout   = reg_write && (reg_addr == ADDR_IOOUT);
  assign wr_funcsel = reg_write && (reg_addr == ADDR_FUNCSEL);

  assign rd_mux = (reg_addr == ADDR_CTRL)    ? {30'h0000_0000, presc_reg} :
                  (reg_addr == ADDR_STATUS)  ? {27'h000_0000, osc_run_reg, active_reg,
                                                cause_reg} :
                  (reg_addr == ADDR_OUTPORT) ? {24'h00_0000, output_port_pins} :
                  (reg_addr == ADDR_IODIR)   ? {20'h0_0000, ~io_port_oe_n} :
                  (reg_addr == ADDR_IOOUT)   ? {20'h0_0000, io_port_out} :
                  (reg_addr == ADDR_FUNCSEL) ? {28'h000_0000, special_func_sel} :
                  32'h0000_0000;

  always_ff @(posedge clock) begin
    if (rst) begin
      presc_reg <= PRESC_RESET;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        presc_reg <= reg_wdata[1:0];
      end
      reg_rdata <= reg_read ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || active_reg) begin
      output_port_pins <= OUTPORT_INIT;
      io_port_oe_n     <= ~IO_INIT;
      io_port_out      <= IO_INIT;
      io_port_pullup   <= IO_PULLUP ? ~IO_INIT : IO_INIT;
      special_func_sel <= FUNCSEL_INIT;
    end else begin
      if (wr_outport) begin
        output_port_pins <= reg_wdata[7:0];
      end
      if (wr_iodir) begin
        io_port_oe_n   <= ~reg_wdata[11:0];
        io_port_pullup <= IO_PULLUP ? ~reg_wdata[11:0] : IO_INIT;
      end
      if (wr_ioout) begin
        io_port_out <= reg_wdata[11:0];
      end
      if (wr_funcsel) begin
        special_func_sel <= reg_wdata[3:0];
      end
    end
  end

  property p_pin_holds;
    @(posedge clock) disable iff (rst)
      pin_filt |-> ##2 cpu_state.cpu_reset;
  endproperty
  a_pin_holds: assert property (p_pin_holds)
    else $error("processor not held while pin reset accepted");

  property p_bypass;
    @(posedge clock) disable iff (rst)
      (!osc_run_reg && !reset_pin_n) |=> pin_filt;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("reset not direct while oscillator stopped");

  property p_osc_loss;
    @(posedge clock) disable iff (rst)
      (osc_run_reg && loss_hit && !osc_rise) |-> ##3 cpu_state.cpu_reset;
  endproperty
  a_osc_loss: assert property (p_osc_loss)
    else $error("oscillator loss did not reset");

  property p_pc_start;
    @(posedge clock) disable iff (rst)
      $fell(cpu_state.cpu_reset) |-> cpu_state.pc_start == PC_RESET;
  endproperty
  a_pc_start: assert property (p_pc_start)
    else $error("wrong start address after reset");

  property p_flags_clear;
    @(posedge clock) disable iff (rst)
      cpu_state.cpu_reset |-> !cpu_state.int_flag && !cpu_state.ext_flag;
  endproperty
  a_flags_clear: assert property (p_flags_clear)
    else $error("flags not cleared by reset");

  property p_mask_pair;
    @(posedge clock) disable iff (rst)
      (!cpu_state.cpu_reset && !cpu_state.int_mask) |-> sp1_done_reg && sp2_done_reg;
  endproperty
  a_mask_pair: assert property (p_mask_pair)
    else $error("interrupts unmasked before both stack pointers");

  property p_ext_set;
    @(posedge clock) disable iff (rst)
      (cpu_event.ext_write && !active_reg) |=> cpu_state.ext_flag;
  endproperty
  a_ext_set: assert property (p_ext_set)
    else $error("extension write did not set flag");

  property p_pins_reset;
    @(posedge clock) disable iff (rst)
      active_reg |=> output_port_pins == OUTPORT_INIT && io_port_oe_n == ~IO_INIT;
  endproperty
  a_pins_reset: assert property (p_pins_reset)
    else $error("shared pins not returned to ports");

  property p_key_reset;
    @(posedge clock) disable iff (rst)
      key_filt |-> ##1 active_reg;
  endproperty
  a_key_reset: assert property (p_key_reset)
    else $error("key reset not merged into active reset");

endmodule

// ===== dv/far_side_model.sv
`timescale 1ns/1ps
module far_side_model #(
  parameter int HALF = 4
) (
  // Clock
  input  wire logic       clock,
  // Requests from the bench
  input  wire logic       osc_run,
  input  wire logic       pin_low,
  input  wire logic [3:0] key_low,
  // Pins toward the block
  output logic            low_speed_oscillator,
  output logic            reset_pin_n,
  output logic [3:0]      key_input_ports
);
  int   cnt = 0;
  logic osc_reg = 1'b0;

  // Oscillator stands low while stopped
  always @(posedge clock) begin
    if (!osc_run) begin
      cnt <= 0;
      osc_reg <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      osc_reg <= ~osc_reg;
    end else begin
      cnt <= cnt + 1;
    end
  end

  assign low_speed_oscillator = osc_reg;
  assign reset_pin_n = ~pin_low;
  assign key_input_ports = ~key_low;
endmodule

// ===== dv/initial_reset_generator_bench.sv
`timescale 1ns/1ps
module initial_reset_generator_bench;
  import rst_gen_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic        reset_pin_n;
  logic [3:0]  key_input_ports;
  logic        low_speed_oscillator;
  cpu_event_t  cpu_event = '0;
  cpu_state_t  cpu_state;
  cpu_state_t  k_state;
  logic [11:0] k_pullup;
  logic        k_seen = 1'b0;
  logic [7:0]  output_port_pins;
  logic [11:0] io_port_out;
  logic [11:0] io_port_oe_n;
  logic [11:0] io_port_pullup;
  logic [3:0]  special_func_sel;
  logic        osc_run = 1'b0;
  logic        pin_low = 1'b1;
  logic [3:0]  key_low = 4'h0;
  logic        rd_pend = 1'b0;
  logic        seen_rst = 1'b0;
  logic [31:0] wd;
  logic [31:0] exp_q[$];
  logic [5:0]  evs[8] = '{6'h02, 6'h01, 6'h02, 6'h01, 6'h20, 6'h10, 6'h08, 6'h04};
  logic [2:0]  exps[8] = '{3'h1, 3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h4, 3'h0};
  int          fails = 0;
  int          checked = 0;

  always #25 clock = ~clock;

  far_side_model #(.HALF(4)) model_u (
    .clock                (clock),
    .osc_run              (osc_run),
    .pin_low              (pin_low),
    .key_low              (key_low),
    .low_speed_oscillator (low_speed_oscillator),
    .reset_pin_n          (reset_pin_n),
    .key_input_ports      (key_input_ports)
  );

  initial_reset_generator #(
    .KEY_MODE        (KEY_ALL4),
    .KEY_HOLD_EN     (1'b0),
    .IO_PULLUP       (1'b1),
    .KEY_HOLD_CYCLES (50)
  ) dut_u (
    .clock                (clock),
    .rst                  (rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_write            (reg_write),
    .reg_read             (reg_read),
    .reg_rdata            (reg_rdata),
    .reset_pin_n          (reset_pin_n),
    .key_input_ports      (key_input_ports),
    .low_speed_oscillator (low_speed_oscillator),
    .cpu_event            (cpu_event),
    .cpu_state            (cpu_state),
    .output_port_pins     (output_port_pins),
    .io_port_out          (io_port_out),
    .io_port_oe_n         (io_port_oe_n),
    .io_port_pullup       (io_port_pullup),
    .special_func_sel     (special_func_sel)
  );

  // Two-key reset behind the hold qualifier, no pull-ups
  initial_reset_generator #(
    .KEY_MODE        (KEY_FIRST2),
    .KEY_HOLD_EN     (1'b1),
    .IO_PULLUP       (1'b0),
    .KEY_HOLD_CYCLES (2000)
  ) key_u (
    .clock                (clock),
    .rst                  (rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_write            (reg_write),
    .reg_read             (reg_read),
    .reg_rdata            (),
    .reset_pin_n          (reset_pin_n),
    .key_input_ports      (key_input_ports),
    .low_speed_oscillator (low_speed_oscillator),
    .cpu_event            (cpu_event),
    .cpu_state            (k_state),
    .output_port_pins     (),
    .io_port_out          (),
    .io_port_oe_n         (),
    .io_port_pullup       (k_pullup),
    .special_func_sel     ()
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic ev(input logic [5:0] e);
    cpu_event <= cpu_event_t'(e);
    @(posedge clock);
    cpu_event <= '0;
    @(posedge clock);
  endtask

  task automatic hold(input logic p, input logic [3:0] k, input int n);
    pin_low <= p;
    key_low <= k;
    repeat (n) @(posedge clock);
  endtask

  task automatic wait_rel();
    repeat (100) if (cpu_state.cpu_reset !== 1'b0) @(posedge clock);
    chk(32'(cpu_state.cpu_reset), 32'h0000_0000);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clock) rd_pend <= reg_read;
  always @(negedge clock) begin
    if (cpu_state.cpu_reset === 1'b1)
      seen_rst = 1'b1;
    if (k_state.cpu_reset === 1'b1)
      k_seen = 1'b1;
    if (rd_pend) begin
      if (exp_q.size() == 0)
        fails++;
      else
        chk(reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    conclude();
  end

  initial begin
    void'($urandom(32'h0d1f));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (50) @(posedge clock);
    chk(32'(cpu_state.cpu_reset), 32'h0000_0001);
    osc_run <= 1'b1;
    repeat (3000) @(posedge clock);
    pin_low <= 1'b0;
    wait_rel();
    chk(32'(cpu_state.pc_start), 32'h0000_0110);
    chk(32'({cpu_state.int_flag, cpu_state.ext_flag, cpu_state.int_mask}), 32'h1);
    chk({output_port_pins, io_port_oe_n, io_port_pullup}, 32'hffff_ffff);
    chk(32'(special_func_sel), 32'h0000_0000);
    chk(32'(k_pullup), 32'h0000_0000);
    rd(ADDR_CTRL, 32'h0000_0002);
    rd(8'h40, 32'h0000_0000);
    wd = $urandom;
    wr(ADDR_OUTPORT, wd);
    @(posedge clock);
    chk(32'(output_port_pins), 32'(wd[7:0]));
    rd(ADDR_OUTPORT, 32'(wd[7:0]));
    wr(ADDR_IODIR, 32'h0000_0a5c);
    wr(ADDR_IOOUT, wd >> 8);
    wr(ADDR_FUNCSEL, 32'h0000_0009);
    chk({io_port_oe_n, io_port_pullup, special_func_sel, 4'h0}, 32'h5a35_a390);
    chk(32'(io_port_out), 32'(wd[19:8]));
    for (int i = 0; i < 8; i++) begin
      ev(evs[i]);
      chk(32'({cpu_state.int_flag, cpu_state.ext_flag, cpu_state.int_mask}), 32'(exps[i]));
    end
    // Short low pulse must be rejected
    seen_rst = 1'b0;
    hold(1'b1, 4'h0, 200 + int'($urandom % 200));
    hold(1'b0, 4'h0, 30);
    chk(32'(seen_rst), 32'h0000_0000);
    hold(1'b1, 4'h0, 3000);
    chk(32'(cpu_state.cpu_reset), 32'h0000_0001);
    chk(32'({cpu_state.int_flag, cpu_state.ext_flag, cpu_state.int_mask}), 32'h1);
    chk({io_port_out, io_port_oe_n, special_func_sel, 4'h0}, 32'h000f_ff00);
    chk(32'(output_port_pins), 32'h0000_00ff);
    pin_low <= 1'b0;
    wait_rel();
    // Three keys are not the selected set
    wr(ADDR_STATUS, 32'h0000_0007);
    seen_rst = 1'b0;
    hold(1'b0, 4'h7, 3000);
    chk(32'(seen_rst), 32'h0000_0000);
    hold(1'b0, 4'hf, 3000);
    chk(32'(cpu_state.cpu_reset), 32'h0000_0001);
    key_low <= 4'h0;
    wait_rel();
    rd(ADDR_STATUS, 32'h0000_0012);
    // Same pulse, rejected at default prescaler, accepted at slow one
    seen_rst = 1'b0;
    hold(1'b1, 4'h0, 600);
    hold(1'b0, 4'h0, 30);
    chk(32'(seen_rst), 32'h0000_0000);
    wr(ADDR_CTRL, 32'(PRESC_32K));
    rd(ADDR_CTRL, 32'h0000_0000);
    seen_rst = 1'b0;
    hold(1'b1, 4'h0, 600);
    hold(1'b0, 4'h0, 30);
    chk(32'(seen_rst), 32'h0000_0001);
    wait_rel();
    wr(ADDR_CTRL, 32'(PRESC_RESET));
    // Oscillator loss
    wr(ADDR_OUTPORT, 32'h0000_0000);
    osc_run <= 1'b0;
    repeat (2100) @(posedge clock);
    chk(32'(cpu_state.cpu_reset), 32'h0000_0001);
    chk(32'(output_port_pins), 32'h0000_00ff);
    osc_run <= 1'b1;
    wait_rel();
    // Keys 0, 1 and 3 low: two-key build resets after the hold time only
    seen_rst = 1'b0;
    k_seen = 1'b0;
    hold(1'b0, 4'hb, 1700);
    chk(32'(k_seen), 32'h0000_0000);
    hold(1'b0, 4'hb, 2500);
    chk(32'(k_state.cpu_reset), 32'h0000_0001);
    chk(32'(seen_rst), 32'h0000_0000);
    key_low <= 4'h0;
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule
